/* common/lcdcfg_pkg.sv */
/*
  Shared constants and carrier types of the panel driver configuration bank:
  serial word layout, register map, reset values, field positions.
  Assumes one 100 MHz core clock samples every pin of the block.
*/
package lcdcfg_pkg;

  // serial transfer word: [23] read request, [22:16] unused, [15:8] address, [7:0] data
  localparam int          FRAME_BITS     = 24;
  localparam logic [4:0]  FRAME_LAST     = 5'h18;
  localparam logic [4:0]  READ_OUT_START = 5'h10;
  localparam int          SYNC_STAGES    = 2;

  // register table, one entry per stored register
  localparam int NUM_REGS = 47;
  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
    8'h0A, 8'h0F, 8'h69, 8'h7F,
    8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29,
    8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39,
    8'h40, 8'h46, 8'h4A, 8'h4B, 8'h4C, 8'h4D,
    8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h5B};
  // panel-tuned entries (gamma, analog trims) come up as zero until loaded
  localparam logic [7:0] TRIM_DEFAULT = 8'h00;
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'h60, 8'h08, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h2B, 8'hCC,
    8'h40, 8'h1C, 8'hFC, 8'h00,
    TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT,
    TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT,
    TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT,
    TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT,
    TRIM_DEFAULT, TRIM_DEFAULT, 8'h00, 8'h00, 8'h00, 8'h00,
    TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT,
    TRIM_DEFAULT, TRIM_DEFAULT};
  // write-only entries read back as zero
  localparam logic [NUM_REGS-1:0] REG_WRITE_ONLY = 47'h00F0_0000_2000;

  // indices of entries that steer logic
  localparam int IDX_SCAN_DIRECTION          = 0;
  localparam int IDX_SOFT_RESET_STANDBY      = 1;
  localparam int IDX_SYNC_POLARITY_V_PORCH   = 9;
  localparam int IDX_PIXEL_CLOCK_EDGE        = 10;
  localparam int IDX_INPUT_FORMAT_PANEL_TYPE = 11;
  localparam int IDX_FLICKER_TRIM            = 34;
  localparam int IDX_TRIM_PROGRAM_ENABLE     = 36;
  localparam int IDX_TRIM_PROGRAM_ADDRESS    = 37;
  localparam int IDX_TRIM_PROGRAM_VALUE      = 38;
  localparam int IDX_TRIM_PROGRAM_CONTROL    = 39;

  // field positions
  localparam int VERTICAL_SCAN_DIRECTION_BIT       = 6;
  localparam int HORIZONTAL_SCAN_DIRECTION_BIT       = 5;
  localparam int SOFT_RESET_BIT = 3;
  localparam int STANDBY_CONTROL_BIT       = 0;
  localparam int VS_POL_BIT     = 7;
  localparam int HS_POL_BIT     = 6;
  localparam int PCLK_POL_BIT   = 6;
  localparam int FORMAT_BIT     = 4;
  localparam int DATA_ENABLE_POLARITY_BIT     = 3;
  localparam int LC_TYPE_BIT    = 1;
  localparam int SWAP_BIT       = 0;
  localparam int TRIM_EN_BIT    = 1;

  localparam logic [1:0] SERIAL_LAST_BYTE = 2'h2;

  typedef struct packed {
    logic       readReq;
    logic [6:0] unused;
    logic [7:0] addr;
    logic [7:0] data;
  } lcdcfg_frame_s;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } lcdcfg_pixel_s;

  typedef struct packed {
    logic parallelInput;
    logic hLeftToRight;
    logic vTopToBottom;
    logic standby;
    logic displayOn;
    logic normallyBlack;
    logic lines272;
    logic trimProgramMode;
    logic autoRefresh;
  } lcdcfg_config_s;

endpackage : lcdcfg_pkg

/* design/lcdcfg_serial_port.sv */
/*
  Three-wire serial port of the configuration bank, run on the core clock.
  Assumes chip select, serial clock and data arrive already synchronised.
*/
`timescale 1ns/10ps
module lcdcfg_serial_port
  import lcdcfg_pkg::*;
(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  // synchronised link pins
  input  wire logic          csN,
  input  wire logic          sclk,
  input  wire logic          sdi,
  output logic               sdo,
  // register side
  output logic [7:0]         readAddr,
  input  wire logic [7:0]    readData,
  output lcdcfg_frame_s      frame,
  output logic               frameValid
);

  logic [FRAME_BITS-1:0] shiftReg;
  logic [4:0]            bitCount;
  logic                  sclkQ;
  logic                  csQ;
  logic [7:0]            readShift;

  wire sclkRise  = sclk & ~sclkQ & ~csN;
  wire sclkFall  = ~sclk & sclkQ & ~csN;
  wire csFall    = ~csN & csQ;
  wire csRise    = csN & ~csQ;
  wire wordFull  = (bitCount == FRAME_LAST);
  wire loadRead  = sclkFall & (bitCount == READ_OUT_START) & shiftReg[READ_OUT_START-1];

  assign readAddr = shiftReg[7:0];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclkQ <= 1'b1;
      csQ   <= 1'b1;
    end
    else
    begin
      sclkQ <= sclk;
      csQ   <= csN;
    end
  end

  // the counter saturates, so longer bursts keep only the newest 24 bits
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      shiftReg <= '0;
      bitCount <= '0;
    end
    else if (csFall)
    begin
      bitCount <= '0;
    end
    else if (sclkRise)
    begin
      shiftReg <= {shiftReg[FRAME_BITS-2:0], sdi};
      bitCount <= wordFull ? bitCount : bitCount + 5'h01;
    end
  end

  // short selections never raise frameValid
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      frameValid <= 1'b0;
      frame      <= '0;
    end
    else
    begin
      frameValid <= csRise & wordFull;
      frame      <= shiftReg;
    end
  end

  // read data goes out on falling edges so the host samples it on rising ones
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      readShift <= '0;
      sdo       <= 1'b0;
    end
    else if (csN)
    begin
      readShift <= '0;
      sdo       <= 1'b0;
    end
    else if (loadRead)
    begin
      readShift <= {readData[6:0], 1'b0};
      sdo       <= readData[7];
    end
    else if (sclkFall && !wordFull && bitCount > READ_OUT_START)
    begin
      readShift <= {readShift[6:0], 1'b0};
      sdo       <= readShift[7];
    end
  end

endmodule : lcdcfg_serial_port

/* design/lcdcfg_config_bank.sv */
/*
  Configuration bank of a TFT panel driver: serial register access, shadow and
  applied register copies, strap pins and pixel input capture.
  Assumes every pin is asynchronous to mclk and the pixel clock is slow
  enough (130 ns period) to be edge-detected by the 100 MHz core clock.
*/
// Functional notes
// - serial bits taken on rising serial clock into 24 bits
// - the serial port works only while chip select is low
// - fewer than 24 clocks: transfer dropped
// - more than 24 clocks: last 24 bits count; reads still take request and address from the first 16 bits
// - format pin low: 8-bit serial RGB on red bus; high: parallel 24-bit
// - default clock polarity samples on falling edge
// - clock polarity pin low positive, high negative, with register bit
// - syncs default negative; pins low positive, high negative
// - data enable active high by default and gates pixel capture
// - horizontal pin low right to left, high left to right
// - vertical pin low bottom to top, high top to bottom
// - swap pin 1 exchanges red and blue bytes, 0 passes them
// - global reset low forces every register to its default
// - standby pin low standby, high normal display
// - panel type pin low normally white, high normally black
// - line count pin low 240 lines, high 272 lines
// - trim mode pin low: auto refresh, no trim programming; high: reverse
// - written values take effect at the next vertical sync, except the soft reset bit and trim programming entries, which act at once
// - only the flicker trim register can be kept in one-time memory
// - effective scan direction is XNOR of pin and register bit
`timescale 1ns/10ps
module lcdcfg_config_bank
  import lcdcfg_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           nrst,
  // three-wire serial port
  input  wire logic           chipSelectN,
  input  wire logic           serialClock,
  input  wire logic           serialDataIn,
  output logic                serialDataOut,
  // pixel input
  input  wire logic           pixelClock,
  input  wire logic           hsync,
  input  wire logic           vsync,
  input  wire logic           dataEnable,
  input  wire logic [7:0]     redDataBus,
  input  wire logic [7:0]     greenDataBus,
  input  wire logic [7:0]     blueDataBus,
  // strap and control pins
  input  wire logic           rgbInputFormatSelect,
  input  wire logic           pixelClockPolarity,
  input  wire logic           verticalSyncPolarity,
  input  wire logic           horizontalSyncPolarity,
  input  wire logic           horizontalScanDirection,
  input  wire logic           verticalScanDirection,
  input  wire logic           redBlueSwap,
  input  wire logic           globalResetN,
  input  wire logic           standbyControl,
  input  wire logic           liquidCrystalType,
  input  wire logic           lineCountSelect,
  input  wire logic           trimModeSelect,
  // to the display core
  output lcdcfg_pixel_s       pixelOut,
  output logic                pixelValid,
  output logic                hsyncActive,
  output logic                frameStart,
  output lcdcfg_config_s      cfg,
  output logic [7:0]          flickerTrim,
  output logic                trimBurnt
);

  localparam int PIN_BITS = 43;

  // synchronisers
  logic [PIN_BITS-1:0] pinMeta;
  logic [PIN_BITS-1:0] pinSync;
  wire  [PIN_BITS-1:0] pinRaw = {chipSelectN, serialClock, serialDataIn, pixelClock, hsync,
                                 vsync, dataEnable, redDataBus, greenDataBus, blueDataBus,
                                 rgbInputFormatSelect, pixelClockPolarity,
                                 verticalSyncPolarity, horizontalSyncPolarity,
                                 horizontalScanDirection, verticalScanDirection,
                                 redBlueSwap, globalResetN, standbyControl,
                                 liquidCrystalType, lineCountSelect, trimModeSelect};

  genvar gp;
  generate
    for (gp = 0; gp < PIN_BITS; gp++)
    begin : g_sync
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          pinMeta[gp] <= 1'b1;
          pinSync[gp] <= 1'b1;
        end
        else
        begin
          pinMeta[gp] <= pinRaw[gp];
          pinSync[gp] <= pinMeta[gp];
        end
      end
    end
  endgenerate

  wire       sCsN     = pinSync[42];
  wire       sSclk    = pinSync[41];
  wire       sSdi     = pinSync[40];
  wire       sPclk    = pinSync[39];
  wire       sHsync   = pinSync[38];
  wire       sVsync   = pinSync[37];
  wire       sDe      = pinSync[36];
  wire [7:0] sRed     = pinSync[35:28];
  wire [7:0] sGreen   = pinSync[27:20];
  wire [7:0] sBlue    = pinSync[19:12];
  wire       sFormat  = pinSync[11];
  wire       sPclkPol = pinSync[10];
  wire       sVsPol   = pinSync[9];
  wire       sHsPol   = pinSync[8];
  wire       sHDir    = pinSync[7];
  wire       sVDir    = pinSync[6];
  wire       sSwap    = pinSync[5];
  wire       sGrstN   = pinSync[4];
  wire       sStandby = pinSync[3];
  wire       sLcType  = pinSync[2];
  wire       sLines   = pinSync[1];
  wire       sTrim    = pinSync[0];

  // serial port
  logic [7:0]    readAddr;
  logic [7:0]    readData;
  lcdcfg_frame_s frame;
  logic          frameValid;

  lcdcfg_serial_port u_serial (
    .mclk       (mclk),
    .nrst       (nrst),
    .csN        (sCsN),
    .sclk       (sSclk),
    .sdi        (sSdi),
    .sdo        (serialDataOut),
    .readAddr   (readAddr),
    .readData   (readData),
    .frame      (frame),
    .frameValid (frameValid)
  );

  // register storage: shadow takes writes, active is what the panel uses
  logic [7:0]          shadowReg [NUM_REGS];
  logic [7:0]          activeReg [NUM_REGS];
  logic [NUM_REGS-1:0] writeHit;
  logic [7:0]          readTerm  [NUM_REGS];
  logic                applyStrobe;
  logic [7:0]          otpValue;
  logic                otpBurnt;

  // soft reset bit and pin both clear the whole table
  wire regClear  = ~sGrstN | ~shadowReg[IDX_SOFT_RESET_STANDBY][SOFT_RESET_BIT];
  wire frameWr   = frameValid & ~frame.readReq;
  wire refreshOn = ~sTrim & otpBurnt;

  genvar gr;
  generate
    for (gr = 0; gr < NUM_REGS; gr++)
    begin : g_reg
      assign writeHit[gr] = frameWr & (frame.addr == REG_ADDR[gr]);
      assign readTerm[gr] = ((readAddr == REG_ADDR[gr]) && !REG_WRITE_ONLY[gr]) ?
                            shadowReg[gr] : 8'h00;
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
          shadowReg[gr] <= REG_RESET[gr];
        else if (regClear)
          shadowReg[gr] <= REG_RESET[gr];
        else if (writeHit[gr])
          shadowReg[gr] <= frame.data;
      end
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
          activeReg[gr] <= REG_RESET[gr];
        else if (regClear)
          activeReg[gr] <= REG_RESET[gr];
        else if (applyStrobe)
          activeReg[gr] <= (gr == IDX_FLICKER_TRIM && refreshOn) ? otpValue
                                                                : shadowReg[gr];
      end
    end
  endgenerate

  always_comb
  begin
    readData = 8'h00;
    for (int i = 0; i < NUM_REGS; i++)
      readData = readData | readTerm[i];
  end

  // one-time trim store; limited to the flicker trim entry
  wire trimAllowed = sTrim & shadowReg[IDX_TRIM_PROGRAM_ENABLE][TRIM_EN_BIT];
  wire trimTarget  = shadowReg[IDX_TRIM_PROGRAM_ADDRESS][6:0]
                     == REG_ADDR[IDX_FLICKER_TRIM][6:0];
  wire burnStrobe  = writeHit[IDX_TRIM_PROGRAM_CONTROL] & (frame.data != 8'h00) &
                     trimAllowed & trimTarget & ~otpBurnt;

  // trim store survives register resets; only nrst clears it
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      otpValue <= TRIM_DEFAULT;
      otpBurnt <= 1'b0;
    end
    else if (burnStrobe)
    begin
      otpValue <= shadowReg[IDX_TRIM_PROGRAM_VALUE];
      otpBurnt <= 1'b1;
    end
  end

  // effective polarities: equal pin and bit keep the pin-high meaning; for swap, equal pin and bit give no swap
  wire [7:0] syncReg    = activeReg[IDX_SYNC_POLARITY_V_PORCH];
  wire [7:0] fmtReg     = activeReg[IDX_INPUT_FORMAT_PANEL_TYPE];
  wire       pclkFallSm = ~(sPclkPol ^ activeReg[IDX_PIXEL_CLOCK_EDGE][PCLK_POL_BIT]);
  wire       vsNeg      = ~(sVsPol ^ syncReg[VS_POL_BIT]);
  wire       hsNeg      = ~(sHsPol ^ syncReg[HS_POL_BIT]);
  wire       deHigh     = fmtReg[DATA_ENABLE_POLARITY_BIT];
  wire       parallelIn = ~(sFormat ^ fmtReg[FORMAT_BIT]);
  wire       swapRb     = sSwap ^ fmtReg[SWAP_BIT];

  // pixel clock edge detection; edges are only seen after two-stage sync
  logic pclkQ;
  logic vsActQ;
  logic [1:0] byteCount;
  logic [7:0] redHold;
  logic [7:0] greenHold;

  wire sampleEdge = pclkFallSm ? (~sPclk & pclkQ) : (sPclk & ~pclkQ);
  wire vsAct      = vsNeg ? ~sVsync : sVsync;
  wire hsAct      = hsNeg ? ~sHsync : sHsync;
  wire deAct      = deHigh ? sDe : ~sDe;
  wire vsStart    = sampleEdge & vsAct & ~vsActQ;
  wire lastByte   = parallelIn | (byteCount == SERIAL_LAST_BYTE);
  wire [7:0] capRed   = parallelIn ? sRed : redHold;
  wire [7:0] capGreen = parallelIn ? sGreen : greenHold;
  wire [7:0] capBlue  = parallelIn ? sBlue : sRed;

  assign applyStrobe = vsStart;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pclkQ  <= 1'b1;
      vsActQ <= 1'b0;
    end
    else
    begin
      pclkQ  <= sPclk;
      vsActQ <= sampleEdge ? vsAct : vsActQ;
    end
  end

  // serial format walks red, green, blue bytes on the red bus
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      byteCount <= '0;
      redHold   <= '0;
      greenHold <= '0;
    end
    else if (sampleEdge)
    begin
      if (!deAct || vsStart || lastByte)
        byteCount <= '0;
      else
        byteCount <= byteCount + 2'h1;
      if (deAct && byteCount == 2'h0)
        redHold <= sRed;
      if (deAct && byteCount == 2'h1)
        greenHold <= sRed;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pixelOut    <= '0;
      pixelValid  <= 1'b0;
      hsyncActive <= 1'b0;
      frameStart  <= 1'b0;
    end
    else
    begin
      pixelValid <= sampleEdge & deAct & lastByte;
      frameStart <= vsStart;
      if (sampleEdge)
        hsyncActive <= hsAct;
      if (sampleEdge && deAct && lastByte)
      begin
        pixelOut.red   <= swapRb ? capBlue : capRed;
        pixelOut.green <= capGreen;
        pixelOut.blue  <= swapRb ? capRed : capBlue;
      end
    end
  end

  // applied configuration towards the panel core
  wire [7:0] dirReg = activeReg[IDX_SCAN_DIRECTION];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg         <= '0;
      flickerTrim <= TRIM_DEFAULT;
      trimBurnt   <= 1'b0;
    end
    else
    begin
      cfg.parallelInput   <= parallelIn;
      cfg.hLeftToRight    <= ~(sHDir ^ dirReg[HORIZONTAL_SCAN_DIRECTION_BIT]);
      cfg.vTopToBottom    <= ~(sVDir ^ dirReg[VERTICAL_SCAN_DIRECTION_BIT]);
      cfg.standby         <= ~sStandby;
      cfg.displayOn       <= activeReg[IDX_SOFT_RESET_STANDBY][STANDBY_CONTROL_BIT];
      cfg.normallyBlack   <= sLcType ^ fmtReg[LC_TYPE_BIT];
      cfg.lines272        <= sLines;
      cfg.trimProgramMode <= sTrim;
      cfg.autoRefresh     <= ~sTrim;
      flickerTrim         <= activeReg[IDX_FLICKER_TRIM];
      trimBurnt           <= otpBurnt;
    end
  end

endmodule : lcdcfg_config_bank

/* tb/lcdcfg_config_bank_asserts.sv */
/* port assertions of the configuration bank
   assumes one mclk domain; bound to every bank instance */
`timescale 1ns/10ps
module lcdcfg_config_bank_asserts
  import lcdcfg_pkg::*;
(
  // clock and reset
  input wire logic           mclk,
  input wire logic           nrst,
  // pins
  input wire logic           chipSelectN,
  input wire logic           vsync,
  input wire logic           dataEnable,
  input wire logic [7:0]     redDataBus,
  input wire logic [7:0]     greenDataBus,
  input wire logic [7:0]     blueDataBus,
  input wire logic           verticalSyncPolarity,
  input wire logic           redBlueSwap,
  input wire logic           globalResetN,
  input wire logic           standbyControl,
  input wire logic           lineCountSelect,
  input wire logic           trimModeSelect,
  // outputs
  input wire logic           serialDataOut,
  input wire lcdcfg_pixel_s  pixelOut,
  input wire logic           pixelValid,
  input wire logic           frameStart,
  input wire lcdcfg_config_s cfg,
  input wire logic [7:0]     flickerTrim
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  // age of the last global reset; its synchroniser delays the clear
  logic [2:0] grAge;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      grAge <= 3'h7;
    else if (!globalResetN)
      grAge <= 3'h0;
    else if (grAge != 3'h7)
      grAge <= grAge + 3'h1;

  property p_standby;
    $stable(standbyControl)[*5] |-> cfg.standby == !standbyControl;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby wrong");
  property p_lines;
    $stable(lineCountSelect)[*5] |-> cfg.lines272 == lineCountSelect;
  endproperty
  a_lines: assert property (p_lines)
    else $error("line count wrong");
  property p_trim;
    $stable(trimModeSelect)[*5] |->
      cfg.trimProgramMode == trimModeSelect && cfg.autoRefresh == !trimModeSelect;
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim mode wrong");
  property p_sdoIdle;
    chipSelectN[*6] |-> !serialDataOut;
  endproperty
  a_sdoIdle: assert property (p_sdoIdle)
    else $error("data out busy while deselected");
  property p_pixPulse;
    pixelValid |=> !pixelValid;
  endproperty
  a_pixPulse: assert property (p_pixPulse)
    else $error("pixel pulse too long");
  property p_pixDe;
    pixelValid |-> $past(dataEnable, 3);
  endproperty
  a_pixDe: assert property (p_pixDe)
    else $error("pixel without data enable");
  property p_pixData;
    pixelValid && cfg.parallelInput |-> pixelOut == (redBlueSwap ?
      {$past(blueDataBus, 2), $past(greenDataBus, 2), $past(redDataBus, 2)} :
      {$past(redDataBus, 2), $past(greenDataBus, 2), $past(blueDataBus, 2)});
  endproperty
  a_pixData: assert property (p_pixData)
    else $error("pixel data wrong");
  property p_frame;
    frameStart && verticalSyncPolarity |-> !$past(vsync, 4) ##1 !frameStart;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame start wrong");
  property p_trimHold;
    $changed(flickerTrim) |-> $past(frameStart) || grAge != 3'h7;
  endproperty
  a_trimHold: assert property (p_trimHold)
    else $error("trim changed off vsync");

  c_serialPix: cover property (pixelValid && !cfg.parallelInput);
  c_frame: cover property (frameStart);
  c_read: cover property ($rose(serialDataOut));
endmodule : lcdcfg_config_bank_asserts

bind lcdcfg_config_bank lcdcfg_config_bank_asserts u_chk (
  .mclk, .nrst, .chipSelectN, .vsync, .dataEnable, .redDataBus, .greenDataBus,
  .blueDataBus, .verticalSyncPolarity, .redBlueSwap, .globalResetN, .standbyControl,
  .lineCountSelect, .trimModeSelect, .serialDataOut, .pixelOut, .pixelValid,
  .frameStart, .cfg, .flickerTrim);

/* tb/lcdcfg_host_model.sv */
/* host side of the three-wire serial port, 125 ns serial clock
   assumes it alone drives select, clock and data in */
`timescale 1ns/10ps
module lcdcfg_host_model
  import lcdcfg_pkg::*;
(
  // serial pins
  output logic      chipSelectN,
  output logic      serialClock,
  output logic      serialDataIn,
  input  wire logic serialDataOut
);
  initial
  begin
    chipSelectN  = 1'h1;
    serialClock  = 1'h0;
    serialDataIn = 1'h1;
  end

  // extra leading bits are ones
  task automatic xfer(input lcdcfg_frame_s w, input int n, output logic [7:0] rd);
    logic [23:0] bits;
    int          k;
    bits = w;
    rd = 8'h00;
    chipSelectN = 1'h0;
    #62.5;
    for (int i = 0; i < n; i++)
    begin
      k = i - (n - FRAME_BITS);
      serialDataIn = (k < 0) ? 1'h1 : bits[23 - k];
      #62.5;
      if (k >= 16)
        rd = {rd[6:0], serialDataOut};
      serialClock = 1'h1;
      #62.5;
      serialClock = 1'h0;
    end
    #62.5;
    chipSelectN  = 1'h1;
    serialDataIn = 1'h1;
    #250;
  endtask : xfer
endmodule : lcdcfg_host_model

/* tb/tb_lcdcfg_config_bank.sv */
/* self-checking bench of the configuration bank
   assumes the host model owns the serial pins */
`timescale 1ns/10ps
module tb_lcdcfg_config_bank
  import lcdcfg_pkg::*;
;
  logic           mclk, nrst, chipSelectN, serialClock, serialDataIn, serialDataOut;
  logic           pixelClock, hsync, vsync, dataEnable, pixelValid, hsyncActive;
  logic [7:0]     redDataBus, greenDataBus, blueDataBus, flickerTrim, rd;
  logic           rgbInputFormatSelect, pixelClockPolarity, verticalSyncPolarity;
  logic           horizontalSyncPolarity, horizontalScanDirection, verticalScanDirection;
  logic           redBlueSwap, globalResetN, standbyControl, liquidCrystalType;
  logic           lineCountSelect, trimModeSelect, frameStart, trimBurnt;
  lcdcfg_pixel_s  pixelOut, lastPix;
  lcdcfg_config_s cfg;
  int             fails, nTests, cycles, pixCount, frames, atRise;
  // address, reset value, written, read back
  logic [31:0]    rows [11] = '{32'h00604040, 32'h01080909, 32'h0240A5A5, 32'h082B5A5A,
    32'h09CCCCCC, 32'h0A404040, 32'h0540FFFF, 32'h7F000100, 32'h4B004000,
    32'h40003C3C, 32'h11007700};
  logic [2:0]     hsTab [4] = '{3'h5, 3'h6, 3'h3, 3'h0};

  lcdcfg_host_model u_host (.chipSelectN, .serialClock, .serialDataIn, .serialDataOut);
  lcdcfg_config_bank uut (.mclk, .nrst, .chipSelectN, .serialClock, .serialDataIn,
    .serialDataOut, .pixelClock, .hsync, .vsync, .dataEnable, .redDataBus, .greenDataBus,
    .blueDataBus, .rgbInputFormatSelect, .pixelClockPolarity, .verticalSyncPolarity,
    .horizontalSyncPolarity, .horizontalScanDirection, .verticalScanDirection,
    .redBlueSwap, .globalResetN, .standbyControl, .liquidCrystalType, .lineCountSelect,
    .trimModeSelect, .pixelOut, .pixelValid, .hsyncActive, .frameStart, .cfg,
    .flickerTrim, .trimBurnt);

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    nTests++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask : w

  task automatic rw(input logic rq, input logic [7:0] a, d, input int n);
    u_host.xfer({rq, 7'h00, a, d}, n, rd);
    w(1);
  endtask : rw

  // one pixel clock period
  task automatic pclk(input logic [7:0] r, g, b, input logic de, input logic vs = 1'h1);
    w(1);
    {redDataBus, greenDataBus, blueDataBus, dataEnable, vsync} = {r, g, b, de, vs};
    pixelClock = 1'h1;
    w(6);
    atRise = pixCount;
    pixelClock = 1'h0;
    w(6);
  endtask : pclk

  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (pixelValid === 1'h1)
    begin
      pixCount++;
      lastPix = pixelOut;
    end
    if (frameStart === 1'h1)
      frames++;
    if (cycles == 30000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    {mclk, nrst, pixelClock, dataEnable, redBlueSwap, liquidCrystalType} = 6'h00;
    {hsync, vsync, globalResetN, standbyControl, lineCountSelect, trimModeSelect} = 6'h3E;
    {rgbInputFormatSelect, pixelClockPolarity, verticalSyncPolarity} = 3'h7;
    {horizontalSyncPolarity, horizontalScanDirection, verticalScanDirection} = 3'h7;
    {redDataBus, greenDataBus, blueDataBus} = 24'h000000;
    w(8);
    nrst = 1'h1;
    w(4);
    foreach (rows[i])
    begin
      rw(1'h1, rows[i][31:24], 8'h00, 24);
      chk("reset value", rows[i][23:16], rd);
      rw(1'h0, rows[i][31:24], rows[i][15:8], 24);
      rw(1'h1, rows[i][31:24], 8'h00, 24);
      chk("read back", rows[i][7:0], rd);
    end
    $display("registers done");
    chk("h direction", 1'h1, cfg.hLeftToRight);
    chk("trim pending", 8'h00, flickerTrim);
    pclk(8'h00, 8'h00, 8'h00, 1'h0, 1'h0);
    chk("frames", 1, frames);
    chk("h direction", 1'h0, cfg.hLeftToRight);
    chk("trim applied", 8'h3C, flickerTrim);
    horizontalScanDirection = 1'h0;
    w(6);
    chk("h direction", 1'h1, cfg.hLeftToRight);
    rw(1'h0, 8'h02, 8'h11, 23);
    rw(1'h1, 8'h02, 8'h00, 24);
    chk("short write", 8'hA5, rd);
    rw(1'h0, 8'h02, 8'h3C, 30);
    rw(1'h1, 8'h02, 8'h00, 24);
    chk("long write", 8'h3C, rd);
    globalResetN = 1'h0;
    w(6);
    globalResetN = 1'h1;
    w(6);
    chk("h direction", 1'h0, cfg.hLeftToRight);
    chk("trim cleared", 8'h00, flickerTrim);
    rw(1'h1, 8'h02, 8'h00, 24);
    chk("global reset", 8'h40, rd);
    horizontalScanDirection = 1'h1;
    $display("serial done");
    for (int k = 0; k < 8; k++)
    begin
      {trimModeSelect, lineCountSelect, standbyControl} = k[2:0];
      {liquidCrystalType, verticalScanDirection} = {k[0], k[1]};
      w(6);
      chk("standby", !k[0], cfg.standby);
      chk("black panel", k[0], cfg.normallyBlack);
      chk("lines", k[1], cfg.lines272);
      chk("v direction", k[1], cfg.vTopToBottom);
      chk("trim mode", {k[2], !k[2]}, {cfg.trimProgramMode, cfg.autoRefresh});
    end
    {trimModeSelect, verticalScanDirection} = 2'h1;
    $display("straps done");
    pclk(8'h11, 8'h22, 8'h33, 1'h1);
    chk("parallel pixel", 24'h112233, lastPix);
    redBlueSwap = 1'h1;
    pclk(8'h11, 8'h22, 8'h33, 1'h1);
    chk("swapped pixel", 24'h332211, lastPix);
    redBlueSwap = 1'h0;
    pclk(8'h44, 8'h55, 8'h66, 1'h0);
    chk("pixel count", 2, pixCount);
    rgbInputFormatSelect = 1'h0;
    pclk(8'hA1, 8'h00, 8'h00, 1'h1);
    pclk(8'hA2, 8'h00, 8'h00, 1'h1);
    pclk(8'hA3, 8'h00, 8'h00, 1'h1);
    chk("serial pixel", 24'hA1A2A3, lastPix);
    chk("pixel count", 3, pixCount);
    {rgbInputFormatSelect, dataEnable, pixelClockPolarity} = 3'h4;
    w(6);
    pclk(8'h44, 8'h55, 8'h66, 1'h1);
    chk("rising sample", 4, atRise);
    chk("rising pixel", 24'h445566, lastPix);
    dataEnable = 1'h0;
    w(2);
    pixelClockPolarity = 1'h1;
    $display("pixels done");
    foreach (hsTab[k])
    begin
      {horizontalSyncPolarity, hsync} = hsTab[k][2:1];
      pclk(8'h00, 8'h00, 8'h00, 1'h0);
      chk("hsync active", hsTab[k][0], hsyncActive);
    end
    $display("syncs done");
    end_of_test();
  end
endmodule : tb_lcdcfg_config_bank
